// >>> lamp_pkg.sv
// constants and types for the probe status lamp controller
// Overview of operation
// - while enumerating, main lamp blinks green at ten hertz.
// - main green lamp goes dark while a command executes, except bi-colour in target reset shows orange.
// - enumerated and idle, no command: main lamp steady green.
// - heartbeat blanks green main lamp 10 ms once every second.
// - heartbeat starts only after seven uninterrupted idle seconds.
// - fatal error blinks main lamp at 1 Hz, red or green by variant.
// - bi-colour variant shows orange main lamp while idle with target reset asserted.
// - build-time choice of single green or green-plus-red main lamp.
// - input lamp green with voltage, orange voltage plus reset, red reset.
// - absent target counts as target reset low, so input lamp red.
// - output lamp off, green supply, orange supply plus reset, red reset.
// - main lamp dark in no defined state; fatal pattern only on fatal.
package lamp_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned FAST_HALF_MS = 50;
	localparam int unsigned FAST_HALF_TICKS = FAST_HALF_MS / TICK_MS;
	localparam int unsigned SLOW_HALF_MS = 500;
	localparam int unsigned SLOW_HALF_TICKS = SLOW_HALF_MS / TICK_MS;
	localparam int unsigned SECOND_TICKS = 1000 / TICK_MS;
	localparam int unsigned BEAT_OFF_TICKS = 10 / TICK_MS;
	localparam int unsigned IDLE_S = 7;
	localparam int unsigned IDLE_TICKS = IDLE_S * SECOND_TICKS;
	// ************************************************************
	// lamp colours, bit 1 red, bit 0 green
	// ************************************************************
	typedef enum logic [1:0] {
		LAMP_OFF = 2'b00,
		LAMP_GREEN = 2'b01,
		LAMP_RED = 2'b10,
		LAMP_ORANGE = 2'b11
	} colour_e;
endpackage : lamp_pkg

// >>> tick_if.sv
// time base signals shared between controller and tick generator
`timescale 1ns/1ns
interface tick_if;
	logic tick;
	logic fast_phase;
	logic slow_phase;
	modport gen (output tick, output fast_phase, output slow_phase);
	modport use_side (input tick, input fast_phase, input slow_phase);
endinterface : tick_if

// >>> lamp_tick_gen.sv
// 10 ms tick and blink phase generator
`timescale 1ns/1ns
module lamp_tick_gen #(
	parameter int unsigned TICK_CYCLES = lamp_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	tick_if.gen tb
);
	if (TICK_CYCLES < 2)
	begin : g_bad_tick
		$error("tick period too short");
	end
	typedef struct packed {
		logic [31:0] div;
		logic [7:0] fast_cnt;
		logic [7:0] slow_cnt;
		logic tick;
		logic fast;
		logic slow;
	} tg_s;
	tg_s r;
	tg_s next_r;
	always_comb
	begin
		next_r = r;
		next_r.tick = 1'b0;
		if (r.div == 32'(TICK_CYCLES - 1))
		begin
			next_r.div = '0;
			next_r.tick = 1'b1;
			if (r.fast_cnt == 8'(lamp_pkg::FAST_HALF_TICKS - 1))
			begin
				next_r.fast_cnt = '0;
				next_r.fast = ~r.fast;
			end
			else
				next_r.fast_cnt = r.fast_cnt + 8'h01;
			if (r.slow_cnt == 8'(lamp_pkg::SLOW_HALF_TICKS - 1))
			begin
				next_r.slow_cnt = '0;
				next_r.slow = ~r.slow;
			end
			else
				next_r.slow_cnt = r.slow_cnt + 8'h01;
		end
		else
			next_r.div = r.div + 32'h1;
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= next_r;
	end
	assign tb.tick = r.tick;
	assign tb.fast_phase = r.fast;
	assign tb.slow_phase = r.slow;
	property p_tick_spacing;
		@(posedge clk_i) disable iff (!rst_n_i)
		tb.tick |=> !tb.tick;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("tick lasted more than one cycle");
endmodule : lamp_tick_gen

// >>> probe_status_indicator_ctrl.sv
// main, input and output status lamp controller for the debug probe
`timescale 1ns/1ns
module probe_status_indicator_ctrl #(
	parameter bit BI_COLOUR = 1'b1,
	parameter int unsigned TICK_CYCLES = lamp_pkg::TICK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic enumerating_i,
	input wire logic idle_i,
	input wire logic cmd_busy_i,
	input wire logic fatal_i,
	input wire logic tgt_volt_i,
	input wire logic tgt_reset_n_i,
	input wire logic supply_en_i,
	input wire logic drive_reset_i,
	output logic main_green_o,
	output logic main_red_o,
	output logic in_green_o,
	output logic in_red_o,
	output logic out_green_o,
	output logic out_red_o
);
	if (TICK_CYCLES < 2)
	begin : g_bad_tick
		$error("tick period too short");
	end
	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] rst_sync;
	logic rst_n;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];
	tick_if tb ();
	lamp_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.tb(tb)
	);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [15:0] idle_cnt;
		logic beat_on;
		logic [7:0] sec_cnt;
		logic [1:0] main;
		logic [1:0] in_lamp;
		logic [1:0] out_lamp;
	} st_s;
	st_s r;
	st_s next_r;
	logic idle_now;
	logic blank;
	lamp_pkg::colour_e main_c;
	lamp_pkg::colour_e in_c;
	lamp_pkg::colour_e out_c;
	always_comb
	begin
		next_r = r;
		idle_now = idle_i && !enumerating_i && !fatal_i && !cmd_busy_i;
		if (!idle_now)
		begin
			next_r.idle_cnt = '0;
			next_r.beat_on = 1'b0;
			next_r.sec_cnt = '0;
		end
		else if (tb.tick)
		begin
			if (!r.beat_on)
			begin
				if (r.idle_cnt == 16'(lamp_pkg::IDLE_TICKS - 1))
				begin
					next_r.beat_on = 1'b1;
					next_r.sec_cnt = '0;
				end
				else
					next_r.idle_cnt = r.idle_cnt + 16'h0001;
			end
			else if (r.sec_cnt == 8'(lamp_pkg::SECOND_TICKS - 1))
				next_r.sec_cnt = '0;
			else
				next_r.sec_cnt = r.sec_cnt + 8'h01;
		end
		// blank first tick of each second
		blank = r.beat_on && (r.sec_cnt < 8'(lamp_pkg::BEAT_OFF_TICKS));
		if (fatal_i)
		begin
			if (!tb.slow_phase)
				main_c = lamp_pkg::LAMP_OFF;
			else
				main_c = BI_COLOUR ? lamp_pkg::LAMP_RED : lamp_pkg::LAMP_GREEN;
		end
		else if (enumerating_i)
			main_c = tb.fast_phase ? lamp_pkg::LAMP_GREEN : lamp_pkg::LAMP_OFF;
		else if (BI_COLOUR && !tgt_reset_n_i && idle_i)
			main_c = lamp_pkg::LAMP_ORANGE;
		else if (idle_i && cmd_busy_i)
			main_c = lamp_pkg::LAMP_OFF;
		else if (idle_i)
			main_c = blank ? lamp_pkg::LAMP_OFF : lamp_pkg::LAMP_GREEN;
		else
			main_c = lamp_pkg::LAMP_OFF;
		// single colour variant never lights red
		if (!BI_COLOUR && main_c == lamp_pkg::LAMP_ORANGE)
			main_c = lamp_pkg::LAMP_GREEN;
		// input lamp, absent target reads as reset low
		if (!tgt_reset_n_i)
			in_c = tgt_volt_i ? lamp_pkg::LAMP_ORANGE : lamp_pkg::LAMP_RED;
		else if (tgt_volt_i)
			in_c = lamp_pkg::LAMP_GREEN;
		else
			in_c = lamp_pkg::LAMP_RED;
		if (supply_en_i)
			out_c = drive_reset_i ? lamp_pkg::LAMP_ORANGE : lamp_pkg::LAMP_GREEN;
		else
			out_c = drive_reset_i ? lamp_pkg::LAMP_RED : lamp_pkg::LAMP_OFF;
		next_r.main = main_c;
		next_r.in_lamp = in_c;
		next_r.out_lamp = out_c;
	end
	always_ff @(posedge core_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end
	assign main_green_o = r.main[0];
	assign main_red_o = r.main[1];
	assign in_green_o = r.in_lamp[0];
	assign in_red_o = r.in_lamp[1];
	assign out_green_o = r.out_lamp[0];
	assign out_red_o = r.out_lamp[1];
	// ************************************************************
	// checks
	// ************************************************************
	property p_busy_dark;
		@(posedge core_clk_i) disable iff (!rst_n)
		(idle_i && cmd_busy_i && !fatal_i && !enumerating_i && tgt_reset_n_i)
		|=> !main_green_o;
	endproperty
	a_busy_dark: assert property (p_busy_dark)
		else $error("main lamp lit during command");
	property p_idle_green;
		@(posedge core_clk_i) disable iff (!rst_n)
		(idle_now && tgt_reset_n_i && !r.beat_on) |=> main_green_o;
	endproperty
	a_idle_green: assert property (p_idle_green)
		else $error("idle lamp not green");
	property p_beat_blank;
		@(posedge core_clk_i) disable iff (!rst_n)
		(idle_now && tgt_reset_n_i && blank) |=> !main_green_o;
	endproperty
	a_beat_blank: assert property (p_beat_blank)
		else $error("heartbeat blank not dark");
	property p_enum_green;
		@(posedge core_clk_i) disable iff (!rst_n)
		(enumerating_i && !fatal_i) |=> !main_red_o;
	endproperty
	a_enum_green: assert property (p_enum_green)
		else $error("enumeration lamp shows red");
	property p_cancel;
		@(posedge core_clk_i) disable iff (!rst_n)
		cmd_busy_i |=> (r.idle_cnt == 16'h0000) && !r.beat_on;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("heartbeat not cancelled");
	property p_beat_late;
		@(posedge core_clk_i) disable iff (!rst_n)
		$rose(r.beat_on) |-> $past(r.idle_cnt) == 16'(lamp_pkg::IDLE_TICKS - 1);
	endproperty
	a_beat_late: assert property (p_beat_late)
		else $error("heartbeat started early");
	property p_fatal_colour;
		@(posedge core_clk_i) disable iff (!rst_n)
		(fatal_i && BI_COLOUR) |=> !main_green_o;
	endproperty
	a_fatal_colour: assert property (p_fatal_colour)
		else $error("fatal lamp shows green");
	property p_reset_orange;
		@(posedge core_clk_i) disable iff (!rst_n)
		(BI_COLOUR && !fatal_i && !enumerating_i && idle_i && !tgt_reset_n_i)
		|=> main_green_o && main_red_o;
	endproperty
	a_reset_orange: assert property (p_reset_orange)
		else $error("target reset not orange");
	property p_input_red;
		@(posedge core_clk_i) disable iff (!rst_n)
		(!tgt_reset_n_i && !tgt_volt_i) |=> in_red_o && !in_green_o;
	endproperty
	a_input_red: assert property (p_input_red)
		else $error("absent target not red");
	property p_input_green;
		@(posedge core_clk_i) disable iff (!rst_n)
		(tgt_volt_i && tgt_reset_n_i) |=> in_green_o && !in_red_o;
	endproperty
	a_input_green: assert property (p_input_green)
		else $error("powered target not green");
	property p_output_off;
		@(posedge core_clk_i) disable iff (!rst_n)
		(!supply_en_i && !drive_reset_i) |=> !out_green_o && !out_red_o;
	endproperty
	a_output_off: assert property (p_output_off)
		else $error("output lamp lit without cause");
	property p_undefined_dark;
		@(posedge core_clk_i) disable iff (!rst_n)
		(!idle_i && !enumerating_i && !fatal_i) |=> !main_green_o && !main_red_o;
	endproperty
	a_undefined_dark: assert property (p_undefined_dark)
		else $error("main lamp lit in no state");
endmodule : probe_status_indicator_ctrl

// >>> lamp_core_model.sv
// probe core and target sense model feeding the lamp controller
`timescale 1ns/1ns
module lamp_core_model (
	input wire logic [1:0] state_i,
	input wire logic busy_i,
	input wire logic attached_i,
	input wire logic rst_req_i,
	input wire logic supply_i,
	input wire logic drive_i,
	output logic enumerating_o,
	output logic idle_o,
	output logic fatal_o,
	output logic busy_o,
	output logic volt_o,
	output logic tgt_reset_n_o,
	output logic supply_en_o,
	output logic drive_reset_o
);
	// ********
	// core state: 0 none, 1 enumerate, 2 idle, 3 fatal
	// ********
	assign enumerating_o = state_i == 2'h1;
	assign idle_o = state_i == 2'h2;
	assign fatal_o = state_i == 2'h3;
	// commands only run once operational
	assign busy_o = busy_i && idle_o;
	// ********
	// target side
	// ********
	assign volt_o = attached_i;
	assign tgt_reset_n_o = attached_i && !rst_req_i;
	assign supply_en_o = supply_i;
	assign drive_reset_o = drive_i;
endmodule : lamp_core_model

// >>> probe_status_indicator_ctrl_tb_top.sv
// self-checking bench for the probe status lamp controller
`timescale 1ns/1ns
`define CMP(nm, ex, ac) \
	begin \
		n_checks++; \
		if ((ac) !== (ex)) \
		begin \
			mismatches++; \
			$display("Error %s exp %0h got %0h", nm, ex, ac); \
		end \
	end
module probe_status_indicator_ctrl_tb_top;
	localparam logic [1:0] O = lamp_pkg::LAMP_OFF;
	localparam logic [1:0] G = lamp_pkg::LAMP_GREEN;
	localparam logic [1:0] R = lamp_pkg::LAMP_RED;
	localparam logic [1:0] Y = lamp_pkg::LAMP_ORANGE;
	typedef struct packed {
		logic [6:0] s;
		logic [5:0] e;
		logic [1:0] m;
	} row_s;
	// stimulus: state, busy, attached, reset request, supply, drive
	// then main, input, output lamps, then single-colour main lamp
	// single colour has no orange, so a command still darkens it
	row_s rows [5] = '{
		'{7'h48, {G, G, O}, G},
		'{7'h5a, {O, G, G}, O},
		'{7'h4f, {Y, Y, Y}, G},
		'{7'h01, {O, R, R}, O},
		'{7'h5c, {Y, Y, O}, O}
	};
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [6:0] stim = 7'h00;
	logic [1:0] sel = 2'h0;
	logic enumerating_i, idle_i, cmd_busy_i, fatal_i, tgt_volt_i;
	logic tgt_reset_n_i, supply_en_i, drive_reset_i, pick;
	logic [5:0] lamps;
	logic [1:0] mono;
	int mismatches = 0;
	int n_checks = 0;
	int n;
	assign pick = sel == 2'h0 ? lamps[4] : sel == 2'h1 ? lamps[5] : mono[0];
	lamp_core_model model (.state_i(stim[6:5]), .busy_i(stim[4]),
		.attached_i(stim[3]), .rst_req_i(stim[2]), .supply_i(stim[1]),
		.drive_i(stim[0]), .enumerating_o(enumerating_i), .idle_o(idle_i),
		.fatal_o(fatal_i), .busy_o(cmd_busy_i), .volt_o(tgt_volt_i),
		.tgt_reset_n_o(tgt_reset_n_i), .supply_en_o(supply_en_i),
		.drive_reset_o(drive_reset_i));
	probe_status_indicator_ctrl #(.BI_COLOUR(1'b1), .TICK_CYCLES(10)) uut (
		.core_clk_i, .rst_n_i, .enumerating_i, .idle_i, .cmd_busy_i,
		.fatal_i, .tgt_volt_i, .tgt_reset_n_i, .supply_en_i, .drive_reset_i,
		.main_green_o(lamps[4]), .main_red_o(lamps[5]),
		.in_green_o(lamps[2]), .in_red_o(lamps[3]),
		.out_green_o(lamps[0]), .out_red_o(lamps[1]));
	probe_status_indicator_ctrl #(.BI_COLOUR(1'b0), .TICK_CYCLES(10)) mono_u (
		.core_clk_i, .rst_n_i, .enumerating_i, .idle_i, .cmd_busy_i,
		.fatal_i, .tgt_volt_i, .tgt_reset_n_i, .supply_en_i, .drive_reset_i,
		.main_green_o(mono[0]), .main_red_o(mono[1]), .in_green_o(),
		.in_red_o(), .out_green_o(), .out_red_o());
	initial
	begin
		forever #4 core_clk_i = ~core_clk_i;
	end
	// ********
	// helpers
	// ********
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// length of the current run of level v, bounded so a stuck lamp ends
	task automatic run_len(input logic v);
		n = 0;
		while (pick === v && n < 12000)
		begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 12000)
		begin
			mismatches++;
			finish_test();
		end
	endtask : run_len
	// skip partial runs first, then time one whole v run and one !v run
	task automatic blink(input logic [1:0] s, input logic v, input int a,
		input int b);
		sel = s;
		// let pick follow the new selection and the new core state
		repeat (2) @(posedge core_clk_i);
		run_len(v);
		run_len(!v);
		run_len(v);
		`CMP("first run", a, n)
		run_len(!v);
		`CMP("second run", b, n)
	endtask : blink
	// ********
	// sequence
	// ********
	initial
	begin
		repeat (5) @(posedge core_clk_i);
		`CMP("reset lamps", 6'h00, lamps)
		@(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		foreach (rows[i])
		begin
			stim <= rows[i].s;
			repeat (4) @(posedge core_clk_i);
			`CMP("lamps", rows[i].e, lamps)
			`CMP("mono", rows[i].m, mono)
		end
		stim <= 7'h08;
		repeat (3) @(posedge core_clk_i);
		stim <= 7'h48;
		run_len(1'b0);
		run_len(1'b1);
		`CMP("idle wait", 1'b1, n >= 6990 && n <= 8020)
		blink(2'h0, 1'b0, 10, 990);
		stim <= 7'h58;
		repeat (20) @(posedge core_clk_i);
		stim <= 7'h48;
		run_len(1'b0);
		run_len(1'b1);
		`CMP("restart", 1'b1, n >= 6990 && n <= 8020)
		stim <= 7'h28;
		blink(2'h0, 1'b1, 50, 50);
		stim <= 7'h68;
		blink(2'h1, 1'b1, 500, 500);
		blink(2'h2, 1'b1, 500, 500);
		`CMP("fatal green", 1'b0, lamps[4])
		finish_test();
	end
endmodule : probe_status_indicator_ctrl_tb_top
